// ### hdl/lwc_defines.svh
// constants and bit layout of the link width control registers
// Behaviour
// RQ1 - two register copies: 0xc4 serves side A, 0xc8 serves side B.
// RQ2 - read-write 3-bit outgoing width; 16-bit code only on side A.
// RQ3 - read-write 3-bit incoming width, same codes, 16-bit only side A.
// RQ4 - both width settings reset only by power good, kept over chip reset.
// RQ5 - after power good, widths default from negotiation with the partner.
// RQ6 - new width takes effect only at chip reset or link-stop disconnect.
// RQ7 - read-only max outgoing width: 16 bits side A, 8 bits side B.
// RQ8 - read-only max incoming width: 16 bits side A, 8 bits side B.
// RQ9 - after link-stop release and seen rx control, hold tx control asserted.
// RQ10 - hold is at least 16 bit times, or about 50 us when selected.
// RQ11 - long hold select cleared only by power good, kept over chip reset.
// RQ12 - low half resets to 0020h; side B max widths read as 00.
// RQ13 - bit 5 reflects the link initialisation outcome, not a fixed value.
// RQ14 - init done set on success, cleared by chip reset or disconnect.
// RQ15 - reserved bits read zero and ignore writes.
`ifndef LWC_DEFINES_SVH
`define LWC_DEFINES_SVH
`define LWC_ADDR_W 12
`define LWC_OFS_A 12'h0c4
`define LWC_OFS_B 12'h0c8
`define LWC_OUT_LO 28
`define LWC_IN_LO 24
`define LWC_MAXO_LO 20
`define LWC_MAXI_LO 16
`define LWC_LONG_BIT 14
`define LWC_DONE_BIT 5
`define LWC_W16 3'h1
`define LWC_W8 3'h0
`define LWC_W4 3'h5
`define LWC_W2 3'h4
`define LWC_WNC 3'h7
`define LWC_SHORT_BITS 16
`define LWC_LONG_HOLD_NS 50000
`define LWC_CLK_NS 25
`define LWC_LONG_CYC (`LWC_LONG_HOLD_NS / `LWC_CLK_NS)
`define LWC_RESP_OKAY 2'h0
`define LWC_RESP_SLVERR 2'h2
`endif

// ### hdl/lwc_pkg.sv
// types and width-code helpers for the link width control block
`include "lwc_defines.svh"
package lwc_pkg;
    typedef logic [2:0] lwc_width_t;
    typedef enum logic [1:0] {
        ST_TRAIN = 2'b00,
        ST_HOLD = 2'b01,
        ST_UP = 2'b10,
        ST_STOP = 2'b11
    } lwc_link_st_t;
    typedef struct packed {
        logic lc_s1, lc_s2, lc_prev, rc_s1, rc_s2, ls_s1, ls_s2;
        lwc_link_st_t st;
        logic from_stop;
        logic [11:0] cnt;
        logic tx_ctl, init_done;
        lwc_width_t act_out, act_in;
    } lwc_side_st_t;
    typedef struct packed {
        logic pg_s1, pg_s2;
        logic [1:0][2:0] po_s1, po_s2, pi_s1, pi_s2;
        logic [1:0][2:0] out_set, in_set;
        logic [1:0] long_sel;
        logic aw_held, w_held, awready, wready, bvalid, arready, rvalid;
        logic [`LWC_ADDR_W-1:0] aw_addr;
        logic [31:0] w_data, rdata;
        logic [3:0] w_strb;
        logic [1:0] bresp, rresp;
    } lwc_top_st_t;
    // 16 bits ranks highest; unknown codes rank as not connected
    function automatic logic [2:0] lwc_rank(input lwc_width_t c);
        unique case (c)
            `LWC_W16: lwc_rank = 3'h4;
            `LWC_W8: lwc_rank = 3'h3;
            `LWC_W4: lwc_rank = 3'h2;
            `LWC_W2: lwc_rank = 3'h1;
            default: lwc_rank = 3'h0;
        endcase
    endfunction
    function automatic logic lwc_code_ok(input lwc_width_t c,
                                         input logic side_a);
        lwc_code_ok = (lwc_rank(c) != 3'h0) || (c == `LWC_WNC);
        if (c == `LWC_W16) begin
            lwc_code_ok = side_a;
        end
    endfunction
endpackage

// ### hdl/lwc_side_if.sv
// settings down to and status up from one tunnel side
`timescale 1ns/100ps
`default_nettype none
interface lwc_side_if;
    logic [2:0] out_set, in_set, act_out, act_in;
    logic long_sel, tx_ctl, init_done;
    modport regs(output out_set, in_set, long_sel,
                 input act_out, act_in, tx_ctl, init_done);
    modport side(input out_set, in_set, long_sel,
                 output act_out, act_in, tx_ctl, init_done);
endinterface
`default_nettype wire

// ### hdl/lwc_side.sv
// link-side sequencing: control-line hold, init done, active widths
`timescale 1ns/100ps
`default_nettype none
module lwc_side import lwc_pkg::*; (
    // clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // link pins
    input wire logic link_clk,
    input wire logic rx_control_line,
    input wire logic link_stop_n,
    // register side
    lwc_side_if.side sif
);
    localparam logic [11:0] SHORT_CNT = 12'(`LWC_SHORT_BITS);
    localparam logic [11:0] LONG_CNT = 12'(`LWC_LONG_CYC);
    lwc_side_st_t r, n;
    logic tick, long_hold;
    logic [11:0] limit;

    always_comb begin
        n = r;
        n.lc_s1 = link_clk;
        n.lc_s2 = r.lc_s1;
        n.lc_prev = r.lc_s2;
        n.rc_s1 = rx_control_line;
        n.rc_s2 = r.rc_s1;
        n.ls_s1 = link_stop_n;
        n.ls_s2 = r.ls_s1;
        // both link clock edges count: each edge is one bit time
        long_hold = r.from_stop && sif.long_sel; // see RQ9
        tick = long_hold | (r.lc_s2 ^ r.lc_prev);
        limit = long_hold ? LONG_CNT : SHORT_CNT; // see RQ10
        if (!aresetn) begin
            n.st = ST_TRAIN;
            n.tx_ctl = 1'b1;
            n.init_done = 1'b0; // see RQ14
            n.from_stop = 1'b0;
            n.cnt = 12'h0;
            n.act_out = sif.out_set; // see RQ6
            n.act_in = sif.in_set;
        end else if (!r.ls_s2 && r.st != ST_STOP) begin
            n.st = ST_STOP;
            n.tx_ctl = 1'b0;
        end else begin
            unique case (r.st)
                ST_TRAIN: begin
                    if (r.rc_s2) begin
                        n.st = ST_HOLD;
                        n.cnt = 12'h0;
                    end
                end
                ST_HOLD: begin
                    if (tick) begin
                        n.cnt = r.cnt + 12'h1;
                    end
                    if (n.cnt >= limit) begin // see RQ10
                        n.st = ST_UP;
                        n.tx_ctl = 1'b0;
                        n.init_done = 1'b1; // see RQ13
                    end
                end
                ST_UP: begin
                end
                ST_STOP: begin
                    // disconnect done: drop status, pick up new widths
                    n.init_done = 1'b0; // see RQ14
                    n.act_out = sif.out_set; // see RQ6
                    n.act_in = sif.in_set;
                    if (r.ls_s2) begin
                        n.st = ST_TRAIN;
                        n.tx_ctl = 1'b1; // see RQ9
                        n.from_stop = 1'b1;
                        n.cnt = 12'h0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (ce || !aresetn) begin
            r <= n;
        end
    end

    assign sif.tx_ctl = r.tx_ctl;
    assign sif.init_done = r.init_done;
    assign sif.act_out = r.act_out;
    assign sif.act_in = r.act_in;
endmodule
`default_nettype wire

// ### hdl/lwc_top.sv
// link width control registers behind an AXI4-Lite slave, two sides
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module lwc_top import lwc_pkg::*; (
    // clock, chip reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // power good, high when supplies are stable
    input wire logic power_good,
    // partner link widths per side, index 0 is side A
    input wire logic [1:0][2:0] partner_out_width,
    input wire logic [1:0][2:0] partner_in_width,
    // link pins per side
    input wire logic [1:0] link_clk,
    input wire logic [1:0] rx_control_line,
    input wire logic [1:0] link_stop_n,
    output logic [1:0] tx_control_line,
    output logic [1:0][2:0] active_out_width,
    output logic [1:0][2:0] active_in_width,
    // axi4-lite write address and data
    input wire logic [`LWC_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [`LWC_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    lwc_top_st_t r, n;
    lwc_side_if sif [2] ();
    logic [1:0] init_done_w;

    // one side per instance, side A is index 0
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gen_side
            assign sif[g].out_set = r.out_set[g];
            assign sif[g].in_set = r.in_set[g];
            assign sif[g].long_sel = r.long_sel[g];
            assign init_done_w[g] = sif[g].init_done;
            assign tx_control_line[g] = sif[g].tx_ctl;
            assign active_out_width[g] = sif[g].act_out;
            assign active_in_width[g] = sif[g].act_in;
            lwc_side u_side (
                .aclk(aclk),
                .aresetn(aresetn),
                .ce(ce),
                .link_clk(link_clk[g]),
                .rx_control_line(rx_control_line[g]),
                .link_stop_n(link_stop_n[g]),
                .sif(sif[g])
            );
        end
    endgenerate

    // word decode: 0 side A, 1 side B, 2 unmapped
    function automatic logic [1:0] decode(
        input logic [`LWC_ADDR_W-1:0] a);
        decode = 2'h2;
        if (a[`LWC_ADDR_W-1:2] == offs_word(`LWC_OFS_A)) begin
            decode = 2'h0; // see RQ1
        end
        if (a[`LWC_ADDR_W-1:2] == offs_word(`LWC_OFS_B)) begin
            decode = 2'h1;
        end
    endfunction
    function automatic logic [`LWC_ADDR_W-3:0] offs_word(
        input logic [`LWC_ADDR_W-1:0] a);
        offs_word = a[`LWC_ADDR_W-1:2];
    endfunction

    // fixed maximum width of each side
    function automatic lwc_width_t max_code(input logic s);
        max_code = s ? `LWC_W8 : `LWC_W16; // see RQ7
    endfunction

    // negotiated default: the narrower of own maximum and partner width
    function automatic lwc_width_t negotiate(input lwc_width_t own,
                                             input lwc_width_t peer);
        negotiate = (lwc_rank(peer) < lwc_rank(own)) ? peer : own;
        if (lwc_rank(peer) == 3'h0) begin
            negotiate = `LWC_WNC;
        end
    endfunction

    // reserved bits and the fields not held here read as zero
    function automatic logic [31:0] read_word(input logic s,
                                              input lwc_top_st_t q,
                                              input logic [1:0] done);
        read_word = 32'h0; // see RQ15
        read_word[`LWC_OUT_LO +: 3] = q.out_set[s]; // see RQ2
        read_word[`LWC_IN_LO +: 3] = q.in_set[s]; // see RQ3
        read_word[`LWC_MAXO_LO +: 3] = max_code(s); // see RQ7
        read_word[`LWC_MAXI_LO +: 3] = max_code(s); // see RQ8
        read_word[`LWC_LONG_BIT] = q.long_sel[s]; // see RQ11
        read_word[`LWC_DONE_BIT] = done[s]; // see RQ13
    endfunction

    logic [1:0] wsel;
    logic [1:0] rsel;
    logic wside;
    lwc_width_t wout, win;

    always_comb begin
        n = r;
        wsel = 2'h2;
        rsel = 2'h2;
        wside = 1'b0;
        wout = 3'h0;
        win = 3'h0;
        n.pg_s1 = power_good;
        n.pg_s2 = r.pg_s1;
        n.po_s1 = partner_out_width;
        n.po_s2 = r.po_s1;
        n.pi_s1 = partner_in_width;
        n.pi_s2 = r.pi_s1;
        // write address and data are taken in either order
        if (s_axi_awvalid && r.awready) begin
            n.aw_held = 1'b1;
            n.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && r.wready) begin
            n.w_held = 1'b1;
            n.w_data = s_axi_wdata;
            n.w_strb = s_axi_wstrb;
        end
        if (r.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
        end
        if (n.aw_held && n.w_held && !n.bvalid) begin
            wsel = decode(n.aw_addr);
            wside = wsel[0];
            wout = n.w_data[`LWC_OUT_LO +: 3];
            win = n.w_data[`LWC_IN_LO +: 3];
            n.aw_held = 1'b0;
            n.w_held = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = wsel[1] ? `LWC_RESP_SLVERR : `LWC_RESP_OKAY;
            // illegal codes are dropped so the field keeps a legal width
            if (!wsel[1] && n.w_strb[3]) begin
                if (lwc_code_ok(wout, !wside)) begin
                    n.out_set[wside] = wout; // see RQ2
                end
                if (lwc_code_ok(win, !wside)) begin
                    n.in_set[wside] = win; // see RQ3
                end
            end
            if (!wsel[1] && n.w_strb[1]) begin
                n.long_sel[wside] = n.w_data[`LWC_LONG_BIT]; // see RQ9
            end
        end
        n.awready = !n.aw_held && !n.bvalid;
        n.wready = !n.w_held && !n.bvalid;
        // read path: one read in flight
        if (r.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
        end
        if (s_axi_arvalid && r.arready) begin
            rsel = decode(s_axi_araddr);
            n.rvalid = 1'b1;
            n.rdata = rsel[1] ? 32'h0 : read_word(rsel[0], r, init_done_w);
            n.rresp = rsel[1] ? `LWC_RESP_SLVERR : `LWC_RESP_OKAY;
        end
        n.arready = !n.rvalid;
        // sticky fields: power good only, chip reset leaves them
        if (!r.pg_s2) begin
            for (int s = 0; s < 2; s++) begin
                n.out_set[s] = negotiate(max_code(s[0]), r.po_s2[s]);
                n.in_set[s] = negotiate(max_code(s[0]), r.pi_s2[s]);
            end // see RQ5
            n.long_sel = 2'h0; // see RQ11
        end // see RQ4
        if (!aresetn) begin
            n.aw_held = 1'b0;
            n.w_held = 1'b0;
            n.awready = 1'b0;
            n.wready = 1'b0;
            n.bvalid = 1'b0;
            n.bresp = `LWC_RESP_OKAY;
            n.arready = 1'b0;
            n.rvalid = 1'b0;
            n.rdata = 32'h0;
            n.rresp = `LWC_RESP_OKAY;
            n.aw_addr = '0;
            n.w_data = 32'h0;
            n.w_strb = 4'h0;
        end
    end

    always_ff @(posedge aclk) begin
        if (ce || !aresetn) begin
            r <= n;
        end
    end

    assign s_axi_awready = r.awready;
    assign s_axi_wready = r.wready;
    assign s_axi_bvalid = r.bvalid;
    assign s_axi_bresp = r.bresp;
    assign s_axi_arready = r.arready;
    assign s_axi_rvalid = r.rvalid;
    assign s_axi_rdata = r.rdata;
    assign s_axi_rresp = r.rresp;
endmodule
`default_nettype wire

// ### bench/lwc_props.sv
// assertions on the link width control top ports
`timescale 1ns/100ps
`default_nettype none
`include "lwc_defines.svh"
module lwc_props (
    // clock and chip reset
    input wire logic aclk,
    input wire logic aresetn,
    // link pins
    input wire logic [1:0] rx_control_line,
    input wire logic [1:0] link_stop_n,
    input wire logic [1:0] tx_control_line,
    input wire logic [1:0][2:0] active_out_width,
    input wire logic [1:0][2:0] active_in_width,
    // register bus
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`LWC_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // all ones only after six cycles free of chip reset and link stop
    logic [5:0] quiet_r;
    always_ff @(posedge aclk) begin
        quiet_r <= {quiet_r[4:0], aresetn & (&link_stop_n)};
    end
    a_bresp_held: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response not held");
    a_rdata_held: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    a_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered next cycle");
    a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address open while data pending");
    a_aw_blocked: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write open while response pending");
    a_unmapped_read: assert property (
        s_axi_arvalid && s_axi_arready && s_axi_araddr != `LWC_OFS_A
        && s_axi_araddr != `LWC_OFS_B |=>
        s_axi_rresp == `LWC_RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    a_width_deferred: assert property (
        $changed({active_out_width, active_in_width}) |-> !(&quiet_r))
        else $error("active width changed without reset or stop");
    a_tx_after_reset: assert property (
        $rose(aresetn) |-> tx_control_line == 2'b11)
        else $error("control line low after chip reset");
    a_tx_held: assert property (
        ($past(tx_control_line & ~rx_control_line & link_stop_n)
        & ~tx_control_line) == 2'b00)
        else $error("control line dropped before partner answered");
endmodule
bind lwc_top lwc_props u_props (
    .aclk, .aresetn, .rx_control_line, .link_stop_n, .tx_control_line,
    .active_out_width, .active_in_width, .s_axi_awready, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready
);
`default_nettype wire

// ### bench/lwc_link_partner.sv
// link partner: answers our control line, clocks the link while training
`timescale 1ns/100ps
`default_nettype none
module lwc_link_partner #(
    parameter int LAG_NS = 150
) (
    // from the tunnel side
    input wire logic tx_ctl,
    // to the tunnel side
    output logic link_clk,
    output logic rx_ctl
);
    initial begin
        link_clk = 1'b0;
        rx_ctl = 1'b0;
        #13;
        // stands still outside training, so idle counts cannot creep in
        forever begin
            #100;
            if (tx_ctl) link_clk = ~link_clk;
        end
    end
    always @(tx_ctl) begin
        if (!tx_ctl) begin
            rx_ctl = 1'b0;
        end else begin
            #(LAG_NS);
            rx_ctl = tx_ctl;
        end
    end
endmodule
`default_nettype wire

// ### bench/lwc_top_tb_top.sv
// bench for link width control: register table, holds and both resets
`timescale 1ns/100ps
`default_nettype none
`include "lwc_defines.svh"
module lwc_top_tb_top;
    logic aclk, aresetn, power_good;
    logic [1:0][2:0] partner_out_width, partner_in_width;
    logic [1:0] link_stop_n;
    wire logic [1:0] link_clk, rx_control_line, tx_control_line;
    wire logic [1:0][2:0] active_out_width, active_in_width;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata;
    logic [3:0] s_axi_wstrb;
    logic s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_rready;
    wire logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    wire logic s_axi_arready, s_axi_rvalid;
    wire logic [1:0] s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata;
    wire logic [31:0] act = {20'h0, active_out_width, active_in_width};
    int err_total = 0;
    int total_checks = 0;
    typedef struct packed {
        logic [11:0] a;
        logic [31:0] d;
        logic [3:0] s;
        logic [1:0] rs;
        logic [31:0] e;
    } lwc_row_t;
    lwc_row_t rows [10] = '{
        '{12'h0c4, 32'hffff_ffff, 4'h0, 2'h0, 32'h5111_0020},
        '{12'h0c8, 32'hffff_ffff, 4'h0, 2'h0, 32'h0400_0020},
        '{12'h0c4, 32'hffff_ffff, 4'hf, 2'h0, 32'h7711_4020},
        '{12'h0c4, 32'h2400_0000, 4'h8, 2'h0, 32'h7411_4020},
        '{12'h0c4, 32'h1500_0000, 4'h8, 2'h0, 32'h1511_4020},
        '{12'h0c8, 32'h1000_0000, 4'hf, 2'h0, 32'h0000_0020},
        '{12'h0c8, 32'h5000_0000, 4'h7, 2'h0, 32'h0000_0020},
        '{12'h0c8, 32'h4500_0000, 4'h8, 2'h0, 32'h4500_0020},
        '{12'h0cc, 32'hffff_ffff, 4'hf, 2'h2, 32'h0},
        '{12'h0c0, 32'hffff_ffff, 4'hf, 2'h2, 32'h0}
    };
    lwc_top uut (
        .aclk, .aresetn, .ce(1'b1), .power_good, .partner_out_width,
        .partner_in_width, .link_clk, .rx_control_line, .link_stop_n,
        .tx_control_line, .active_out_width, .active_in_width,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready
    );
    // side b answers slowly; lags off whole cycles so rx never races aclk
    lwc_link_partner #(.LAG_NS(160)) pa (.tx_ctl(tx_control_line[0]),
        .link_clk(link_clk[0]), .rx_ctl(rx_control_line[0]));
    lwc_link_partner #(.LAG_NS(910)) pb (.tx_ctl(tx_control_line[1]),
        .link_clk(link_clk[1]), .rx_ctl(rx_control_line[1]));
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [1:0] r);
        int n;
        r = 2'h3;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 100 && r === 2'h3; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
            end
        end
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e,
                         input logic [31:0] m);
        logic [31:0] d;
        logic [1:0] r;
        int n;
        r = 2'h3;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 100 && r === 2'h3; n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
            end
        end
        chk(d & m, e);
        chk({30'h0, r}, (a == `LWC_OFS_A || a == `LWC_OFS_B) ? 0 : 2);
    endtask
    task automatic up;
        for (int n = 0; n < 500 && tx_control_line !== 2'b00; n++) begin
            @(posedge aclk);
        end
        chk({30'h0, tx_control_line}, 32'h0);
    endtask
    // cycles from partner answer to our control line dropping
    task automatic hold(input int s, output int c);
        c = 0;
        for (int n = 0; n < 3000 && rx_control_line[s] !== 1'b1; n++) begin
            @(posedge aclk);
        end
        for (int n = 0; n < 3000 && tx_control_line[s] !== 1'b0; n++) begin
            @(posedge aclk);
            c++;
        end
    endtask
    initial begin
        logic [1:0] r;
        int cyc;
        aresetn = 1'b0;
        power_good = 1'b0;
        link_stop_n = 2'b11;
        partner_out_width = {3'h1, 3'h5};
        partner_in_width = {3'h4, 3'h1};
        s_axi_awaddr = 12'h0;
        s_axi_araddr = 12'h0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'h0;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        power_good <= 1'b1;
        up();
        chk(act, 32'h161);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d, rows[i].s, r);
            chk({30'h0, r}, {30'h0, rows[i].rs});
            rdchk(rows[i].a, rows[i].e, '1);
        end
        chk(act, 32'h161);
        link_stop_n[0] <= 1'b0;
        repeat (10) @(posedge aclk);
        chk(act, 32'h065);
        rdchk(12'h0c4, 32'h1511_4000, '1);
        link_stop_n[0] <= 1'b1;
        hold(0, cyc);
        chk(32'(cyc >= 2000 && cyc < 2012), 32'h1);
        rdchk(12'h0c4, 32'h1511_4020, '1);
        link_stop_n[1] <= 1'b0;
        repeat (10) @(posedge aclk);
        link_stop_n[1] <= 1'b1;
        hold(1, cyc);
        chk(32'(cyc >= 64 && cyc < 80), 32'h1);
        chk(act, 32'h86d);
        aresetn <= 1'b0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        rdchk(12'h0c4, 32'h1511_4000, '1);
        up();
        rdchk(12'h0c4, 32'h1511_4020, '1);
        partner_out_width <= {3'h1, 3'h0};
        partner_in_width <= {3'h4, 3'h2};
        power_good <= 1'b0;
        repeat (6) @(posedge aclk);
        power_good <= 1'b1;
        repeat (4) @(posedge aclk);
        rdchk(12'h0c4, 32'h0711_0000, 32'hffff_ffdf);
        rdchk(12'h0c8, 32'h0400_0000, 32'hffff_ffdf);
        complete_run();
    end
    initial begin
        repeat (20000) @(posedge aclk);
        err_total++;
        complete_run();
    end
endmodule
`default_nettype wire
